//--- npes_cfg.svh
// Command codes, status bit positions and geometry constants of the sequencer
`ifndef NPES_CFG_SVH
`define NPES_CFG_SVH

// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define NPES_CMD_READ 8'h00
`define NPES_CMD_READ_GO 8'h30
`define NPES_CMD_CB_READ_GO 8'h35
`define NPES_CMD_PROG 8'h80
`define NPES_CMD_PROG2 8'h81
`define NPES_CMD_COLCHG 8'h85
`define NPES_CMD_PROG_GO 8'h10
`define NPES_CMD_PROG_NEXT 8'h11
`define NPES_CMD_ERASE 8'h60
`define NPES_CMD_ERASE_GO 8'hd0
`define NPES_CMD_STATUS 8'h70
`define NPES_CMD_STATUS_DUAL 8'h71
`define NPES_CMD_RESET 8'hff

// ----------------------------------------------------------------------------
// Status byte bit positions (bit 0 is the lowest I/O line)
// ----------------------------------------------------------------------------
`define NPES_ST_FAIL 0
`define NPES_ST_FAIL_D0 1
`define NPES_ST_FAIL_D1 2
`define NPES_ST_REWRITE 3
`define NPES_ST_READY_A 5
`define NPES_ST_READY_B 6
`define NPES_ST_WP_N 7

// ----------------------------------------------------------------------------
// Address and sector geometry
// ----------------------------------------------------------------------------
`define NPES_ADDR_LAST 3'h4
`define NPES_ADDR_ROW_FIRST 3'h2
`define NPES_ADDR_COL_LAST 3'h1
`define NPES_DISTRICT_BIT 6
`define NPES_MAIN_SIZE 13'h1000
`define NPES_SPARE_END 13'h1080
`define NPES_ECC_CORRECT 4'h8
`define NPES_ECC_REWRITE_DEF 4'h6
// Pin levels while idle: deselected, strobes and write-protect high
`define NPES_PINS_IDLE 14'h0f00

`endif

//--- npes_core_model.sv
// Behavioural array core that answers sequencer requests
`timescale 1ns/100ps
`default_nettype none

module npes_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request and answer
    input wire npes_pkg::npes_array_req_t req,
    input wire logic [7:0] lat,
    input wire logic [1:0] fail_cfg,
    input wire logic [3:0] err_cfg,
    output logic done,
    output logic [1:0] fail,
    output logic [3:0] max_errors
);
    logic [7:0] cnt;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            {cnt, done} <= 9'h000;
        else
            {cnt, done} <= {req.start ? lat : cnt - {7'h00, cnt != 8'h00}, cnt == 8'h01};
    end
    // Stale answers are inverted so a late sample cannot pass by luck
    assign fail = done ? fail_cfg : ~fail_cfg;
    assign max_errors = done ? err_cfg : ~err_cfg;
endmodule
`default_nettype wire

//--- npes_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module npes_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins
    input wire logic [W-1:0] pin,
    output logic [W-1:0] value
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] v;
    } npes_sync_state_t;

    npes_sync_state_t r_q;
    npes_sync_state_t r_d;

    if (W < 1)
    begin : g_bad_width
        $error("npes_pin_sync: W must be at least 1");
    end

    // Stage one feeds only stage two; the filter looks at two and three
    always_comb
    begin
        r_d = r_q;
        r_d.s1 = pin;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        for (int i = 0; i < W; i++)
        begin
            if (r_q.s2[i] == r_q.s3[i]) r_d.v[i] = r_q.s3[i];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        // Idle levels out of reset, so no false strobe edge follows it
        if (rst) r_q <= {INIT, INIT, INIT, INIT};
        else r_q <= r_d;
    end

    assign value = r_q.v;

endmodule
`default_nettype wire

//--- npes_pkg.sv
// Types shared by the sequencer modules
package npes_pkg;

    typedef enum logic [2:0] {
        NPES_IDLE,
        NPES_ADDR,
        NPES_DATA,
        NPES_WAIT_SECOND,
        NPES_ERASE_WAIT,
        NPES_READ_WAIT,
        NPES_BUSY
    } npes_state_t;

    typedef enum logic [1:0] {
        NPES_OP_READ,
        NPES_OP_PROG,
        NPES_OP_ERASE,
        NPES_OP_COPYBACK
    } npes_op_t;

    typedef enum logic [1:0] {
        NPES_STAT_NONE,
        NPES_STAT_SINGLE,
        NPES_STAT_DUAL
    } npes_stat_t;

    typedef struct packed {
        logic cle;
        logic ale;
        logic ce_n;
        logic we_n;
        logic output_strobe_n;
        logic wp_n;
        logic [7:0] io;
    } npes_pins_t;

    typedef struct packed {
        logic start;
        npes_op_t kind;
        logic [1:0] districts;
        logic [16:0] row_d0;
        logic [16:0] row_d1;
        logic [7:0] sectors;
    } npes_array_req_t;

    typedef struct packed {
        logic we;
        logic [12:0] col;
        logic [2:0] sector;
        logic spare;
        logic [7:0] data;
    } npes_buf_wr_t;

endpackage

//--- npes_sector_map.sv
// Column to ECC sector mapping
`timescale 1ns/100ps
`default_nettype none
`include "npes_cfg.svh"

module npes_sector_map (
    // Column in
    input wire logic [12:0] col,
    // Sector out
    output logic [2:0] sector,
    output logic spare,
    output logic in_page
);

    logic [12:0] spare_off;

    assign spare_off = col - `NPES_MAIN_SIZE;

    always_comb
    begin
        if (col < `NPES_MAIN_SIZE)
        begin
            sector = col[11:9];
            spare = 1'b0;
            in_page = 1'b1;
        end
        else if (col < `NPES_SPARE_END)
        begin
            sector = spare_off[6:4];
            spare = 1'b1;
            in_page = 1'b1;
        end
        else
        begin
            sector = 3'h0;
            spare = 1'b1;
            in_page = 1'b0;
        end
    end

endmodule
`default_nettype wire

//--- npes_seq.sv
// Command sequencer for program, erase, copy-back and status of a NAND array
//----------------------------------------------------------------------------
//----------------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "npes_cfg.svh"

module npes_seq #(
    parameter logic [3:0] REWRITE_LEVEL = `NPES_ECC_REWRITE_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Flash pins
    input wire npes_pkg::npes_pins_t pins,
    output logic [7:0] io_out,
    output logic io_oe,
    output logic ready_busy_n,
    // Array core request
    output npes_pkg::npes_array_req_t array_req,
    input wire logic array_done,
    input wire logic [1:0] array_fail,
    input wire logic [3:0] array_max_errors,
    // Page buffer write port
    output npes_pkg::npes_buf_wr_t buf_wr
);

    //------------------------------------------------------------------------
    // State
    //------------------------------------------------------------------------
    typedef struct packed {
        npes_pkg::npes_state_t st;
        npes_pkg::npes_op_t op;
        npes_pkg::npes_stat_t stat;
        logic we_prev;
        logic [2:0] acnt;
        logic [2:0] alast;
        logic colchg;
        logic second;
        logic cb_ready;
        logic [12:0] col;
        logic [16:0] row;
        logic [1:0] fail;
        logic rd_fail;
        logic rewrite;
        logic [7:0] io_out;
        logic io_oe;
        logic rb_n;
        npes_pkg::npes_array_req_t req;
        npes_pkg::npes_buf_wr_t bw;
    } npes_seq_state_t;

    npes_seq_state_t r_q;
    npes_seq_state_t r_d;
    npes_pkg::npes_pins_t p;
    logic [2:0] sector;
    logic spare;
    logic in_page;
    logic strobe;
    logic [7:0] status;
    logic slot;

    if (REWRITE_LEVEL > `NPES_ECC_CORRECT)
    begin : g_bad_level
        $error("npes_seq: REWRITE_LEVEL above correction limit");
    end

    //------------------------------------------------------------------------
    // Pin synchronisers and sector map
    //------------------------------------------------------------------------
    npes_pin_sync #(
        .W($bits(npes_pkg::npes_pins_t)),
        .INIT(`NPES_PINS_IDLE)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .pin(pins),
        .value(p)
    );

    npes_sector_map u_map (
        .col(r_q.col),
        .sector(sector),
        .spare(spare),
        .in_page(in_page)
    );

    // Latch on the rising write strobe only while selected
    assign strobe = p.we_n & ~r_q.we_prev & ~p.ce_n;
    assign slot = r_q.row[`NPES_DISTRICT_BIT];

    //------------------------------------------------------------------------
    // Status byte
    //------------------------------------------------------------------------
    always_comb
    begin
        status = 8'h00;
        status[`NPES_ST_READY_A] = r_q.rb_n;
        status[`NPES_ST_READY_B] = r_q.rb_n;
        status[`NPES_ST_WP_N] = p.wp_n;
        if (r_q.stat == npes_pkg::NPES_STAT_DUAL)
        begin
            status[`NPES_ST_FAIL] = |r_q.fail;
            status[`NPES_ST_FAIL_D0] = r_q.fail[0];
            status[`NPES_ST_FAIL_D1] = r_q.fail[1];
        end
        else
        begin
            status[`NPES_ST_FAIL] = (|r_q.fail) | r_q.rd_fail;
            status[`NPES_ST_REWRITE] = r_q.rewrite;
        end
    end

    //------------------------------------------------------------------------
    // Sequencer
    //------------------------------------------------------------------------
    always_comb
    begin
        r_d = r_q;
        r_d.we_prev = p.we_n;
        r_d.req.start = 1'b0;
        r_d.bw.we = 1'b0;
        r_d.io_oe = ~p.ce_n & ~p.output_strobe_n & (r_q.stat != npes_pkg::NPES_STAT_NONE);
        r_d.io_out = status;
        r_d.rb_n = (r_q.st != npes_pkg::NPES_BUSY);

        if (r_q.st == npes_pkg::NPES_BUSY && array_done)
        begin
            r_d.rb_n = 1'b1;
            r_d.st = npes_pkg::NPES_IDLE;
            if (r_q.op == npes_pkg::NPES_OP_READ)
            begin
                r_d.rd_fail = array_max_errors > `NPES_ECC_CORRECT;
                r_d.rewrite = (array_max_errors >= REWRITE_LEVEL) &&
                    (array_max_errors <= `NPES_ECC_CORRECT);
            end
            else
            begin
                r_d.fail = array_fail & r_q.req.districts;
            end
        end

        if (strobe && p.cle && !p.ale)
        begin
            // While busy only the two status commands get through
            if (r_q.st == npes_pkg::NPES_BUSY)
            begin
                if (p.io == `NPES_CMD_STATUS) r_d.stat = npes_pkg::NPES_STAT_SINGLE;
                if (p.io == `NPES_CMD_STATUS_DUAL) r_d.stat = npes_pkg::NPES_STAT_DUAL;
            end
            else if (p.io == `NPES_CMD_STATUS)
            begin
                r_d.stat = npes_pkg::NPES_STAT_SINGLE;
            end
            else if (p.io == `NPES_CMD_STATUS_DUAL)
            begin
                r_d.stat = npes_pkg::NPES_STAT_DUAL;
            end
            else
            begin
                r_d.stat = npes_pkg::NPES_STAT_NONE;
                r_d.rd_fail = 1'b0;
                r_d.rewrite = 1'b0;
                r_d.colchg = 1'b0;
                r_d.acnt = 3'h0;
                r_d.alast = `NPES_ADDR_LAST;
                case (p.io)
                    `NPES_CMD_READ:
                    begin
                        r_d.st = npes_pkg::NPES_ADDR;
                        r_d.op = npes_pkg::NPES_OP_READ;
                        r_d.cb_ready = 1'b0;
                    end
                    `NPES_CMD_PROG:
                    begin
                        r_d.st = npes_pkg::NPES_ADDR;
                        r_d.op = npes_pkg::NPES_OP_PROG;
                        r_d.second = 1'b0;
                        r_d.cb_ready = 1'b0;
                        r_d.req.districts = 2'b00;
                        r_d.req.sectors = 8'h00;
                    end
                    `NPES_CMD_PROG2:
                    begin
                        if (r_q.st == npes_pkg::NPES_WAIT_SECOND)
                        begin
                            r_d.st = npes_pkg::NPES_ADDR;
                            r_d.second = 1'b1;
                        end
                        else
                        begin
                            r_d.st = npes_pkg::NPES_IDLE;
                        end
                    end
                    `NPES_CMD_COLCHG:
                    begin
                        if (r_q.st == npes_pkg::NPES_DATA)
                        begin
                            r_d.st = npes_pkg::NPES_ADDR;
                            r_d.colchg = 1'b1;
                            r_d.alast = `NPES_ADDR_COL_LAST;
                        end
                        else if (r_q.cb_ready)
                        begin
                            r_d.st = npes_pkg::NPES_ADDR;
                            r_d.op = npes_pkg::NPES_OP_COPYBACK;
                            r_d.second = 1'b0;
                            r_d.req.districts = 2'b00;
                            r_d.req.sectors = 8'h00;
                        end
                        else
                        begin
                            r_d.st = npes_pkg::NPES_IDLE;
                        end
                    end
                    `NPES_CMD_PROG_GO, `NPES_CMD_PROG_NEXT:
                    begin
                        r_d.st = npes_pkg::NPES_IDLE;
                        if (r_q.st == npes_pkg::NPES_DATA)
                        begin
                            // Store this page's row in its district slot
                            r_d.req.districts[slot] = 1'b1;
                            if (slot) r_d.req.row_d1 = r_q.row;
                            else r_d.req.row_d0 = r_q.row;
                            if (p.io == `NPES_CMD_PROG_NEXT && !r_q.second &&
                                r_q.op == npes_pkg::NPES_OP_PROG)
                            begin
                                r_d.st = npes_pkg::NPES_WAIT_SECOND;
                            end
                            else if (p.io == `NPES_CMD_PROG_GO && p.wp_n)
                            begin
                                // Parity for the touched sectors is built by the core while busy
                                r_d.st = npes_pkg::NPES_BUSY;
                                r_d.req.start = 1'b1;
                                r_d.req.kind = r_q.op;
                                r_d.rb_n = 1'b0;
                                r_d.fail = 2'b00;
                                r_d.cb_ready = 1'b0;
                            end
                            else if (!p.wp_n)
                            begin
                                r_d.cb_ready = 1'b0;
                            end
                        end
                    end
                    `NPES_CMD_ERASE:
                    begin
                        if (r_q.st != npes_pkg::NPES_ERASE_WAIT)
                        begin
                            r_d.req.districts = 2'b00;
                        end
                        r_d.st = npes_pkg::NPES_ADDR;
                        r_d.op = npes_pkg::NPES_OP_ERASE;
                        r_d.cb_ready = 1'b0;
                        r_d.acnt = `NPES_ADDR_ROW_FIRST;
                    end
                    `NPES_CMD_ERASE_GO:
                    begin
                        r_d.st = npes_pkg::NPES_IDLE;
                        if (r_q.st == npes_pkg::NPES_ERASE_WAIT && p.wp_n)
                        begin
                            r_d.st = npes_pkg::NPES_BUSY;
                            r_d.req.start = 1'b1;
                            r_d.req.kind = npes_pkg::NPES_OP_ERASE;
                            r_d.rb_n = 1'b0;
                            r_d.fail = 2'b00;
                        end
                    end
                    `NPES_CMD_READ_GO, `NPES_CMD_CB_READ_GO:
                    begin
                        r_d.st = npes_pkg::NPES_IDLE;
                        if (r_q.st == npes_pkg::NPES_READ_WAIT)
                        begin
                            r_d.st = npes_pkg::NPES_BUSY;
                            r_d.req.start = 1'b1;
                            r_d.req.kind = npes_pkg::NPES_OP_READ;
                            r_d.req.districts = 2'b00;
                            r_d.req.districts[slot] = 1'b1;
                            r_d.req.row_d0 = r_q.row;
                            r_d.req.row_d1 = r_q.row;
                            r_d.rb_n = 1'b0;
                            r_d.cb_ready = (p.io == `NPES_CMD_CB_READ_GO);
                        end
                    end
                    default:
                    begin
                        // Reset and unknown codes drop any open sequence
                        r_d.st = npes_pkg::NPES_IDLE;
                        r_d.cb_ready = 1'b0;
                    end
                endcase
            end
        end
        else if (strobe && p.ale && !p.cle && r_q.st == npes_pkg::NPES_ADDR)
        begin
            case (r_q.acnt)
                3'h0: r_d.col[7:0] = p.io;
                3'h1: r_d.col[12:8] = p.io[4:0];
                3'h2: r_d.row[7:0] = p.io;
                3'h3: r_d.row[15:8] = p.io;
                default: r_d.row[16] = p.io[0];
            endcase
            r_d.acnt = r_q.acnt + 3'h1;
            if (r_q.acnt == r_q.alast)
            begin
                if (r_q.colchg || r_q.op == npes_pkg::NPES_OP_PROG ||
                    r_q.op == npes_pkg::NPES_OP_COPYBACK)
                begin
                    r_d.st = npes_pkg::NPES_DATA;
                end
                else if (r_q.op == npes_pkg::NPES_OP_ERASE)
                begin
                    // Block picks its district slot, either order taken
                    r_d.st = npes_pkg::NPES_ERASE_WAIT;
                    r_d.req.districts[r_d.row[`NPES_DISTRICT_BIT]] = 1'b1;
                    if (r_d.row[`NPES_DISTRICT_BIT]) r_d.req.row_d1 = r_d.row;
                    else r_d.req.row_d0 = r_d.row;
                end
                else
                begin
                    r_d.st = npes_pkg::NPES_READ_WAIT;
                end
            end
        end
        else if (strobe && !p.ale && !p.cle && r_q.st == npes_pkg::NPES_DATA)
        begin
            // Bytes past the spare area are dropped, never wrapped
            if (in_page)
            begin
                r_d.bw.we = 1'b1;
                r_d.bw.col = r_q.col;
                r_d.bw.sector = sector;
                r_d.bw.spare = spare;
                r_d.bw.data = p.io;
                r_d.req.sectors[sector] = 1'b1;
                r_d.col = r_q.col + 13'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            r_q <= '0;
            r_q.we_prev <= 1'b1;
            r_q.rb_n <= 1'b1;
            r_q.alast <= `NPES_ADDR_LAST;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    //------------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------------
    assign io_out = r_q.io_out;
    assign io_oe = r_q.io_oe;
    assign ready_busy_n = r_q.rb_n;
    assign array_req = r_q.req;
    assign buf_wr = r_q.bw;

endmodule
`default_nettype wire

//--- npes_seq_monitor.sv
// Port assertions of the command sequencer
`timescale 1ns/100ps
`default_nettype none

module npes_seq_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched ports
    input wire npes_pkg::npes_pins_t pins,
    input wire logic [7:0] io_out,
    input wire logic io_oe,
    input wire logic ready_busy_n,
    input wire npes_pkg::npes_array_req_t array_req,
    input wire logic array_done,
    input wire npes_pkg::npes_buf_wr_t buf_wr
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_busy_start; array_req.start |=> !ready_busy_n; endproperty
    a_busy_start: assert property (p_busy_start) else $error("no busy at start");
    property p_busy_hold; !ready_busy_n && !array_done |=> !ready_busy_n; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
    property p_ready_back; !ready_busy_n && array_done |=> ready_busy_n; endproperty
    a_ready_back: assert property (p_ready_back) else $error("ready not back");
    property p_wp_block; (!pins.wp_n) [*8] |-> !(array_req.start && array_req.kind != npes_pkg::NPES_OP_READ);
    endproperty
    a_wp_block: assert property (p_wp_block) else $error("start while protected");
    property p_st_wp; $stable(pins.wp_n) [*8] ##0 io_oe |-> io_out[7] == pins.wp_n; endproperty
    a_st_wp: assert property (p_st_wp) else $error("protect bit wrong");
    property p_st_rdy; $stable(ready_busy_n) [*4] ##0 io_oe |-> io_out[6:5] == {2{ready_busy_n}}; endproperty
    a_st_rdy: assert property (p_st_rdy) else $error("ready bits wrong");
    property p_sec_main; buf_wr.we && buf_wr.col < 13'h1000 |-> !buf_wr.spare && buf_wr.sector == buf_wr.col[11:9];
    endproperty
    a_sec_main: assert property (p_sec_main) else $error("main sector wrong");
    property p_sec_spare; buf_wr.we && buf_wr.col[12] && buf_wr.col < 13'h1080 |-> buf_wr.spare
        && buf_wr.sector == buf_wr.col[6:4]; endproperty
    a_sec_spare: assert property (p_sec_spare) else $error("spare sector wrong");
endmodule

bind npes_seq npes_seq_monitor u_mon (.clk, .rst, .pins, .io_out, .io_oe, .ready_busy_n, .array_req,
    .array_done, .buf_wr);
`default_nettype wire

//--- npes_seq_test.sv
// Self-checking bench of the command sequencer
`timescale 1ns/100ps
`default_nettype none

module npes_seq_test;
    logic clk;
    logic rst;
    npes_pkg::npes_pins_t pins;
    logic [7:0] io_out;
    logic io_oe;
    logic ready_busy_n;
    npes_pkg::npes_array_req_t req;
    npes_pkg::npes_array_req_t last;
    npes_pkg::npes_buf_wr_t bw;
    npes_pkg::npes_buf_wr_t lastw;
    logic done;
    logic [1:0] fail;
    logic [3:0] merr;
    logic [1:0] fail_cfg = 2'h0;
    logic [3:0] err_cfg = 4'h0;
    int error_cnt = 0;
    int n_tests = 0;
    int nstart = 0;
    int nbw = 0;

    npes_seq DUT (.clk(clk), .rst(rst), .pins(pins), .io_out(io_out), .io_oe(io_oe), .ready_busy_n(ready_busy_n),
        .array_req(req), .array_done(done), .array_fail(fail), .array_max_errors(merr), .buf_wr(bw));
    npes_core_model u_core (.clk(clk), .rst(rst), .req(req), .lat(8'h3c), .fail_cfg(fail_cfg),
        .err_cfg(err_cfg), .done(done), .fail(fail), .max_errors(merr));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (req.start)
            last <= req;
        if (bw.we)
            lastw <= bw;
        nstart <= nstart + int'(req.start);
        nbw <= nbw + int'(bw.we);
    end

    // --------
    // Pin cycles
    // --------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Slow strobes: the pin filter needs each level held for two clocks, answers lag about five
    task automatic wr(input logic [1:0] kind, input logic [7:0] b);
        {pins.cle, pins.ale, pins.io} = {kind, b};
        repeat (5) @(negedge clk);
        pins.we_n = 1'b0;
        repeat (6) @(negedge clk);
        pins.we_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    task automatic row3(input logic [16:0] row);
        wr(2'b01, row[7:0]);
        wr(2'b01, row[15:8]);
        wr(2'b01, {7'h00, row[16]});
    endtask
    task automatic addr(input logic [12:0] col, input logic [16:0] row);
        wr(2'b01, col[7:0]);
        wr(2'b01, {3'h0, col[12:8]});
        row3(row);
    endtask
    task automatic run(input logic [1:0] kind);
        chk("busy", ready_busy_n, 1'b0);
        for (int i = 0; i < 200 && ready_busy_n !== 1'b1; i++)
            @(negedge clk);
        chk("ready", ready_busy_n, 1'b1);
        chk("kind", last.kind, kind);
    endtask
    task automatic stat(input logic [7:0] cmd, input logic [7:0] exp);
        wr(2'b10, cmd);
        pins.output_strobe_n = 1'b0;
        repeat (8) @(negedge clk);
        chk("oe", io_oe, 1'b1);
        chk("status", io_out, exp);
        pins.output_strobe_n = 1'b1;
        repeat (8) @(negedge clk);
        chk("oe off", io_oe, 1'b0);
    endtask

    // --------
    // Scenarios
    // --------
    task automatic s_prog;
        wr(2'b10, 8'h80);
        addr(13'h1000, 17'h00040);
        wr(2'b00, 8'ha5);
        wr(2'b00, 8'h5a);
        wr(2'b10, 8'h85);
        wr(2'b01, 8'h00);
        wr(2'b01, 8'h02);
        wr(2'b00, 8'h3c);
        chk("writes", nbw, 3);
        chk("wcol", lastw.col, 13'h0200);
        chk("wdata", lastw.data, 8'h3c);
        wr(2'b10, 8'h10);
        run(npes_pkg::NPES_OP_PROG);
        chk("row", last.row_d1, 17'h00040);
        chk("dist", last.districts, 2'b10);
        chk("sectors", last.sectors, 8'h03);
        stat(8'h70, 8'he0);
    endtask
    task automatic s_multi;
        fail_cfg = 2'b10;
        wr(2'b10, 8'h80);
        addr(13'h0000, 17'h00041);
        wr(2'b00, 8'h11);
        wr(2'b10, 8'h11);
        wr(2'b10, 8'h81);
        addr(13'h0000, 17'h00001);
        wr(2'b00, 8'h22);
        wr(2'b10, 8'h10);
        run(npes_pkg::NPES_OP_PROG);
        chk("row", last.row_d0, 17'h00001);
        chk("row1", last.row_d1, 17'h00041);
        stat(8'h71, 8'he5);
        stat(8'h70, 8'he1);
        fail_cfg = 2'b00;
    endtask
    task automatic s_erase;
        wr(2'b10, 8'h60);
        row3(17'h000c0);
        wr(2'b10, 8'h60);
        row3(17'h00080);
        wr(2'b10, 8'hd0);
        run(npes_pkg::NPES_OP_ERASE);
        chk("dist", last.districts, 2'b11);
        stat(8'h71, 8'he0);
    endtask
    task automatic s_wp;
        int n;
        n = nstart;
        wr(2'b10, 8'h60);
        row3(17'h00140);
        wr(2'b10, 8'hff);
        wr(2'b10, 8'hd0);
        chk("abort", nstart, n);
        pins.wp_n = 1'b0;
        wr(2'b10, 8'h60);
        row3(17'h00100);
        wr(2'b10, 8'hd0);
        chk("starts", nstart, n);
        stat(8'h70, 8'h60);
        pins.wp_n = 1'b1;
    endtask
    task automatic s_copy;
        err_cfg = 4'hf;
        wr(2'b10, 8'h00);
        addr(13'h0000, 17'h000c0);
        wr(2'b10, 8'h30);
        run(npes_pkg::NPES_OP_READ);
        stat(8'h70, 8'he1);
        err_cfg = 4'h7;
        wr(2'b10, 8'h00);
        addr(13'h0000, 17'h00080);
        wr(2'b10, 8'h35);
        run(npes_pkg::NPES_OP_READ);
        stat(8'h70, 8'he8);
        wr(2'b10, 8'h85);
        addr(13'h0000, 17'h00100);
        wr(2'b10, 8'h10);
        run(npes_pkg::NPES_OP_COPYBACK);
        stat(8'h70, 8'he0);
    endtask

    task automatic complete_run;
        if (error_cnt == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        pins = {3'b000, 3'b111, 8'h00};
        rst = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
        s_prog();
        s_multi();
        s_erase();
        s_wp();
        s_copy();
        complete_run();
    end
    initial
    begin
        #2ms;
        error_cnt++;
        complete_run();
    end
endmodule
`default_nettype wire
